// File: design/swu_pkg.sv
package swu_pkg;
  // ==========================================
  // datagram framing
  localparam logic [7:0] SYNC_REQ = 8'h05; // 1010 then 0000, lsb first
  localparam logic [7:0] SYNC_RPL = 8'hf5; // 1010 then 1111, lsb first
  localparam logic [2:0] RD_LAST = 3'h2; // sync, address, crc
  localparam logic [2:0] DG_LAST = 3'h6; // sync, address, four data, crc
  localparam logic [3:0] FIRST_IDX = 4'h4; // first sampled bit after sync edges
  localparam logic [3:0] DATA_LAST = 4'h8;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // ==========================================
  // timing, mostly in bit times
  localparam int MEAS_W = 18;
  localparam logic [15:0] MIN_BIT_CLKS = 16'h0010;
  localparam logic [15:0] DEF_BIT_CLKS = 16'h0064;
  localparam logic [7:0] GAP_BITS = 8'h3f;
  localparam logic [7:0] RECOVER_BITS = 8'h0c;
  localparam logic [7:0] RELEASE_BITS = 8'h04;
  localparam logic [7:0] DELAY_STEP_BITS = 8'h08;
  localparam logic [3:0] DELAY_DEF_STEPS = 4'h1;
  localparam logic [7:0] RSP_WAIT_BITS = 8'hff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOST_BIT_NS = 1000;
  localparam logic [15:0] HOST_BIT_CLKS = 16'(HOST_BIT_NS / CLK_PERIOD_NS);

  // ==========================================
  // crc helpers
  function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
    crc8_bit = {c[6:0], c[7] ^ c[1] ^ c[0] ^ b};
  endfunction

  // bytewise form, lsb first over the byte
  function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crc8_bit(r, d[i]);
    end
    crc8_byte = r;
  endfunction

  localparam logic [7:0] CRC_AFTER_SYNC = crc8_byte(CRC_INIT, SYNC_REQ);
endpackage

// File: design/swu_link_if.sv
// ==========================================
// single wire link, true and complement lines
interface swu_link_if;
  logic host_true;
  logic host_comp;
  logic host_true_oe_n;
  logic host_comp_oe_n;
  logic dev_true;
  logic dev_comp;
  logic dev_true_oe_n;
  logic dev_comp_oe_n;
  logic line_true;
  logic line_comp;

  // wired level: idle true line is pulled high, complement low
  assign line_true = !dev_true_oe_n ? dev_true : (!host_true_oe_n ? host_true : 1'b1);
  assign line_comp = !dev_comp_oe_n ? dev_comp : (!host_comp_oe_n ? host_comp : 1'b0);

  modport host (
    output host_true, host_comp, host_true_oe_n, host_comp_oe_n,
    input line_true, line_comp
  );
  modport device (
    output dev_true, dev_comp, dev_true_oe_n, dev_comp_oe_n,
    input line_true, line_comp
  );
endinterface

// File: design/swu_crc8.sv
// ==========================================
// bit serial crc register
module swu_crc8
  import swu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic [7:0] init_val_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [7:0] crc_o
);
  logic [7:0] crc_q;
  logic [7:0] crc_d;

  // init wins over a shift in the same cycle
  always_comb begin
    crc_d = crc_q;
    if (init_i) begin
      crc_d = init_val_i;
    end else if (shift_i) begin
      crc_d = crc8_bit(crc_q, bit_i);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;
endmodule

// File: design/swu_device.sv
// Summary of operation
// - read request is sync, address, crc
// - reply uses the request's measured baud
// - reply waits steps of eight bit times
// - reply is sync, address, data, crc
// - lsb first bits, high byte first
// - drivers released four bits after reply
// - reply data shifted live, no snapshot
// - host repeats read on bad crc; swu_host only reports it
// - host avoids reading fast-changing values; swu_host leaves it to the user
// - crc8 over all bytes, seed zero
// - serial crc shifts left, xor 7,1,0
// - datagrams with bad crc are ignored
// - good write datagram bumps counter
// - true line plus inverted complement line
// - both lines inputs while idle, receiving
// - bit time remeasured from every sync
// - read reply drives both lines
// - four bit times span first to third fall
// - bytes framed by start and stop
// - counter eight bits, wraps, reads untouched
// - gap over 63 bits resets, 12 idle
module swu_device
  import swu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  swu_link_if.device link,
  input wire logic [3:0] reply_delay_setting_i,
  input wire logic [31:0] rd_data_i,
  output logic [6:0] reg_addr_o,
  output logic wr_stb_o,
  output logic [31:0] wr_data_o,
  output logic [7:0] datagram_count_o,
  output logic rx_err_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SYNC, ST_BITS, ST_WAIT, ST_DELAY, ST_TX, ST_HOLD, ST_RECOVER
  } swu_dev_st_t;

  swu_dev_st_t st_q, st_d;
  logic [15:0] clk_q, clk_d, bt_q, bt_d;
  logic [MEAS_W-1:0] meas_q, meas_d;
  logic fall_q, fall_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] bits_q, bits_d, sh_q, sh_d, cnt_q, cnt_d;
  logic [2:0] byte_q, byte_d;
  logic [6:0] addr_q, addr_d;
  logic wr_q, wr_d, stb_q, stb_d, err_q, err_d;
  logic [31:0] data_q, data_d;
  logic tx_q, tx_d, txn_q, txn_d, oe_n_q, oe_n_d, prev_q;
  logic tick, fall, rx, fail, is_crc;
  logic [7:0] txb, dly, crc;
  logic [3:0] steps;
  logic crc_init, crc_shift, crc_bit;
  logic [7:0] crc_init_val;

  // the complement line is optional, so only the true line is decoded
  assign rx = link.line_true;
  assign fall = prev_q & ~rx;
  assign tick = (clk_q == bt_q - 16'h0001);
  assign is_crc = (byte_q == (wr_q ? DG_LAST : RD_LAST));
  // setting of zero falls back to one step of eight bit times
  assign steps = (reply_delay_setting_i == 4'h0) ? DELAY_DEF_STEPS : reply_delay_setting_i;
  assign dly = 8'(8'(steps) * DELAY_STEP_BITS);

  // reply byte, data bytes read live from the register port
  always_comb begin
    case (byte_q)
      3'h0: txb = SYNC_RPL;
      3'h1: txb = {1'b0, addr_q};
      3'h2: txb = rd_data_i[31:24];
      3'h3: txb = rd_data_i[23:16];
      3'h4: txb = rd_data_i[15:8];
      3'h5: txb = rd_data_i[7:0];
      default: txb = crc;
    endcase
  end

  swu_crc8 u_crc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .init_val_i(crc_init_val),
    .shift_i(crc_shift),
    .bit_i(crc_bit),
    .crc_o(crc)
  );

  // ==========================================
  // receive, reply and recovery sequencing
  always_comb begin
    st_d = st_q;
    clk_d = tick ? 16'h0000 : clk_q + 16'h0001;
    bt_d = bt_q;
    meas_d = meas_q;
    fall_d = fall_q;
    bit_d = bit_q;
    bits_d = bits_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    addr_d = addr_q;
    wr_d = wr_q;
    data_d = data_q;
    tx_d = tx_q;
    txn_d = txn_q;
    oe_n_d = oe_n_q;
    stb_d = 1'b0;
    err_d = 1'b0;
    fail = 1'b0;
    crc_init = 1'b0;
    crc_init_val = CRC_INIT;
    crc_shift = 1'b0;
    crc_bit = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (fall) begin
          st_d = ST_SYNC;
          meas_d = {{(MEAS_W-1){1'b0}}, 1'b1};
          fall_d = 1'b0;
        end
      end
      // four bit times from start fall to the fall between bits 2 and 3
      ST_SYNC: begin
        meas_d = meas_q + 1'b1;
        if (&meas_q) begin
          fail = 1'b1;
        end else if (fall && !fall_q) begin
          fall_d = 1'b1;
        end else if (fall) begin
          bt_d = meas_q[MEAS_W-1:2];
          if (meas_q[MEAS_W-1:2] < MIN_BIT_CLKS) begin
            fail = 1'b1;
          end else begin
            st_d = ST_BITS;
            bit_d = FIRST_IDX;
            clk_d = {1'b0, meas_q[MEAS_W-1:3]};
            bits_d = 8'h00;
            byte_d = 3'h0;
            crc_init = 1'b1;
            crc_init_val = CRC_AFTER_SYNC;
          end
        end
      end
      ST_BITS: begin
        if (tick) begin
          bits_d = bits_q + 8'h01;
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h0) begin
            fail = rx;
          end else if (bit_q <= DATA_LAST) begin
            sh_d = {rx, sh_q[7:1]};
            crc_shift = !is_crc && (byte_q != 3'h0);
            crc_bit = rx;
          end else if (!rx) begin
            fail = 1'b1;
          end else if (byte_q == 3'h1) begin
            addr_d = sh_q[6:0];
            wr_d = sh_q[7];
            byte_d = 3'h2;
            st_d = ST_WAIT;
          end else if (!is_crc) begin
            data_d = {data_q[23:0], sh_q};
            byte_d = byte_q + 3'h1;
            st_d = ST_WAIT;
          end else if (sh_q != crc) begin
            fail = 1'b1;
          end else if (wr_q) begin
            stb_d = 1'b1;
            cnt_d = cnt_q + 8'h01;
            st_d = ST_IDLE;
          end else begin
            st_d = ST_DELAY;
            bits_d = 8'h00;
          end
        end
      end
      // between bytes: start of next byte or gap timeout
      ST_WAIT: begin
        if (fall) begin
          st_d = ST_BITS;
          bit_d = 4'h0;
          clk_d = {1'b0, bt_q[15:1]};
          bits_d = 8'h00;
        end else if (tick) begin
          bits_d = bits_q + 8'h01;
          fail = (bits_q >= GAP_BITS);
        end
      end
      ST_DELAY: begin
        if (tick) begin
          bits_d = bits_q + 8'h01;
          if (bits_q == dly - 8'h01) begin
            st_d = ST_TX;
            oe_n_d = 1'b0;
            tx_d = 1'b0;
            txn_d = 1'b1;
            byte_d = 3'h0;
            bit_d = 4'h0;
            crc_init = 1'b1;
          end
        end
      end
      ST_TX: begin
        if (tick) begin
          if (bit_q == STOP_IDX) begin
            bit_d = 4'h0;
            if (byte_q == DG_LAST) begin
              st_d = ST_HOLD;
              bits_d = 8'h00;
            end else begin
              byte_d = byte_q + 3'h1;
              tx_d = 1'b0;
              txn_d = 1'b1;
            end
          end else begin
            bit_d = bit_q + 4'h1;
            if (bit_q == DATA_LAST) begin
              tx_d = 1'b1;
              txn_d = 1'b0;
            end else begin
              tx_d = txb[bit_q[2:0]];
              txn_d = ~txb[bit_q[2:0]];
              crc_shift = (byte_q != DG_LAST);
              crc_bit = txb[bit_q[2:0]];
            end
          end
        end
      end
      // keep driving idle level before handing the wire back
      ST_HOLD: begin
        if (tick) begin
          bits_d = bits_q + 8'h01;
          if (bits_q == RELEASE_BITS - 8'h01) begin
            oe_n_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
      end
      ST_RECOVER: begin
        if (!rx) begin
          bits_d = 8'h00;
          clk_d = 16'h0000;
        end else if (tick) begin
          bits_d = bits_q + 8'h01;
          if (bits_q == RECOVER_BITS - 8'h01) begin
            st_d = ST_IDLE;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // any framing, timing or crc fault drops the datagram with no reply and pulses rx_err_o
    if (fail) begin
      st_d = ST_RECOVER;
      bits_d = 8'h00;
      err_d = 1'b1;
      oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      clk_q <= 16'h0000;
      bt_q <= DEF_BIT_CLKS;
      meas_q <= '0;
      fall_q <= 1'b0;
      bit_q <= 4'h0;
      bits_q <= 8'h00;
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      byte_q <= 3'h0;
      addr_q <= 7'h00;
      wr_q <= 1'b0;
      data_q <= 32'h0000_0000;
      stb_q <= 1'b0;
      err_q <= 1'b0;
      tx_q <= 1'b1;
      txn_q <= 1'b0;
      oe_n_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      clk_q <= clk_d;
      bt_q <= bt_d;
      meas_q <= meas_d;
      fall_q <= fall_d;
      bit_q <= bit_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      data_q <= data_d;
      stb_q <= stb_d;
      err_q <= err_d;
      tx_q <= tx_d;
      txn_q <= txn_d;
      oe_n_q <= oe_n_d;
      prev_q <= rx;
    end
  end

  assign link.dev_true = tx_q;
  assign link.dev_comp = txn_q;
  assign link.dev_true_oe_n = oe_n_q;
  assign link.dev_comp_oe_n = oe_n_q;
  assign reg_addr_o = addr_q;
  assign wr_stb_o = stb_q;
  assign wr_data_o = data_q;
  assign datagram_count_o = cnt_q;
  assign rx_err_o = err_q;
endmodule

// File: design/swu_host.sv
// ==========================================
// bus master end, fixed baud
module swu_host
  import swu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  swu_link_if.host link,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [6:0] req_addr_i,
  input wire logic [31:0] req_data_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_ok_o,
  output logic [31:0] rsp_data_o
);
  typedef enum logic [2:0] {H_GUARD, H_IDLE, H_TX, H_WAIT, H_RX} swu_host_st_t;

  swu_host_st_t st_q, st_d;
  logic [15:0] clk_q, clk_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] byte_q, byte_d;
  logic [7:0] bits_q, bits_d, sh_q, sh_d, txb, crc;
  logic [6:0] addr_q, addr_d;
  logic [31:0] data_q, data_d;
  logic wr_q, wr_d, tx_q, tx_d, oe_n_q, oe_n_d, prev_q;
  logic rdy_q, rdy_d, vld_q, vld_d, ok_q, ok_d, good_q, good_d;
  logic tick, rx, fall, last, crc_init, crc_shift, crc_bit;

  assign rx = link.line_true;
  assign fall = prev_q & ~rx;
  assign tick = (clk_q == HOST_BIT_CLKS - 16'h0001);
  assign last = (byte_q == (wr_q ? DG_LAST : RD_LAST));
  // request byte: sync, access bit with address, data high first, crc
  assign txb = (byte_q == 3'h0) ? SYNC_REQ : (byte_q == 3'h1) ? {wr_q, addr_q} :
    last ? crc : data_q[31:24];

  swu_crc8 u_crc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .init_val_i(CRC_INIT),
    .shift_i(crc_shift),
    .bit_i(crc_bit),
    .crc_o(crc)
  );

  // ==========================================
  // request, reply and idle guard sequencing
  always_comb begin
    st_d = st_q;
    clk_d = tick ? 16'h0000 : clk_q + 16'h0001;
    bit_d = bit_q;
    byte_d = byte_q;
    bits_d = bits_q;
    sh_d = sh_q;
    addr_d = addr_q;
    data_d = data_q;
    wr_d = wr_q;
    tx_d = tx_q;
    oe_n_d = oe_n_q;
    rdy_d = rdy_q;
    vld_d = 1'b0;
    ok_d = ok_q;
    good_d = good_q;
    crc_init = 1'b0;
    crc_shift = 1'b0;
    crc_bit = 1'b0;
    case (st_q)
      // idle wire before each datagram lets a confused slave resync
      H_GUARD: begin
        if (!rx) begin
          bits_d = 8'h00;
        end else if (tick) begin
          bits_d = bits_q + 8'h01;
          if (bits_q == RECOVER_BITS - 8'h01) begin
            st_d = H_IDLE;
            rdy_d = 1'b1;
          end
        end
      end
      H_IDLE: begin
        if (req_valid_i) begin
          rdy_d = 1'b0;
          wr_d = req_write_i;
          addr_d = req_addr_i;
          data_d = req_data_i;
          st_d = H_TX;
          byte_d = 3'h0;
          bit_d = 4'h0;
          clk_d = 16'h0000;
          tx_d = 1'b0;
          oe_n_d = 1'b0;
          crc_init = 1'b1;
        end
      end
      H_TX: begin
        if (tick) begin
          bit_d = bit_q + 4'h1;
          if (bit_q == STOP_IDX) begin
            bit_d = 4'h0;
            byte_d = byte_q + 3'h1;
            data_d = (byte_q >= 3'h2) ? {data_q[23:0], 8'h00} : data_q;
            tx_d = 1'b0;
            if (last) begin
              tx_d = 1'b1;
              oe_n_d = 1'b1;
              bits_d = 8'h00;
              byte_d = 3'h0;
              crc_init = 1'b1;
              good_d = 1'b1;
              st_d = wr_q ? H_GUARD : H_WAIT;
            end
          end else if (bit_q == DATA_LAST) begin
            tx_d = 1'b1;
          end else begin
            tx_d = txb[bit_q[2:0]];
            crc_shift = !last;
            crc_bit = txb[bit_q[2:0]];
          end
        end
      end
      H_WAIT: begin
        if (fall) begin
          st_d = H_RX;
          bit_d = 4'h0;
          clk_d = {1'b0, HOST_BIT_CLKS[15:1]};
        end else if (tick) begin
          bits_d = bits_q + 8'h01;
          if (bits_q == RSP_WAIT_BITS) begin
            vld_d = 1'b1;
            ok_d = 1'b0;
            bits_d = 8'h00;
            st_d = H_GUARD;
          end
        end
      end
      H_RX: begin
        if (tick) begin
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h0) begin
            good_d = good_q & ~rx;
          end else if (bit_q <= DATA_LAST) begin
            sh_d = {rx, sh_q[7:1]};
            crc_shift = (byte_q != DG_LAST);
            crc_bit = rx;
          end else begin
            bits_d = 8'h00;
            byte_d = byte_q + 3'h1;
            st_d = H_WAIT;
            if (byte_q == 3'h0) begin
              good_d = good_q & rx & (sh_q == SYNC_RPL);
            end else if (byte_q == 3'h1) begin
              good_d = good_q & rx & (sh_q == {1'b0, addr_q});
            end else if (byte_q != DG_LAST) begin
              good_d = good_q & rx;
              data_d = {data_q[23:0], sh_q};
            end else begin
              // bad crc is only reported; a retry or a latched copy is the user's call
              vld_d = 1'b1;
              ok_d = good_q & rx & (sh_q == crc);
              st_d = H_GUARD;
            end
          end
        end
      end
      default: begin
        st_d = H_GUARD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= H_GUARD;
      clk_q <= 16'h0000;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      bits_q <= 8'h00;
      sh_q <= 8'h00;
      addr_q <= 7'h00;
      data_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      tx_q <= 1'b1;
      oe_n_q <= 1'b1;
      prev_q <= 1'b1;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
      ok_q <= 1'b0;
      good_q <= 1'b0;
    end else begin
      st_q <= st_d;
      clk_q <= clk_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      data_q <= data_d;
      wr_q <= wr_d;
      tx_q <= tx_d;
      oe_n_q <= oe_n_d;
      prev_q <= rx;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
      ok_q <= ok_d;
      good_q <= good_d;
    end
  end

  // complement follows the true line from the same registers
  assign link.host_true = tx_q;
  assign link.host_comp = ~tx_q;
  assign link.host_true_oe_n = oe_n_q;
  assign link.host_comp_oe_n = oe_n_q;
  assign req_ready_o = rdy_q;
  assign rsp_valid_o = vld_q;
  assign rsp_ok_o = ok_q;
  assign rsp_data_o = data_q;
endmodule

// File: sim/swu_sva.sv
// ==========================================
// link checker, watches both ends of one link
module swu_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic host_true,
  input wire logic host_comp,
  input wire logic host_true_oe_n,
  input wire logic dev_true,
  input wire logic dev_comp,
  input wire logic dev_true_oe_n,
  input wire logic dev_comp_oe_n,
  input wire logic line_true
);
  logic [15:0] run_q;
  logic [15:0] hi_q;
  logic [15:0] gap_q;
  logic [15:0] drv_q;

  // ==========================================
  // cycle counters; run_q and gap_q saturate so long idles never wrap to a false zero
  always_ff @(posedge sys_clk_i) begin
    run_q <= (rst_i || $changed(line_true)) ? 16'h0000 : run_q + 16'(run_q != 16'hffff);
    hi_q <= (!dev_true_oe_n && dev_true) ? hi_q + 16'h0001 : 16'h0000;
    gap_q <= host_true_oe_n ? gap_q + 16'(gap_q != 16'hffff) : 16'h0000;
    drv_q <= !dev_true_oe_n ? drv_q + 16'h0001 : 16'h0000;
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================
  // wire timing and pin rules
  AST_BIT_SPACING: assert property ($changed(line_true) |-> run_q >= 16'h005a)
    else $error("line edge closer than a bit time");
  // high crc bits may run into the stop bit, so the upper end allows eight more bits
  AST_RELEASE_HIGH: assert property ($rose(dev_true_oe_n) |->
    hi_q >= 16'h01ea && hi_q <= 16'h051e)
    else $error("line not held high through stop and hold");
  AST_DRIVE_LEN: assert property ($rose(dev_true_oe_n) |->
    drv_q >= 16'h1cb6 && drv_q <= 16'h1d4c)
    else $error("reply drive time is not seventy four bit times");
  AST_TURN_DELAY: assert property ($fell(dev_true_oe_n) |-> gap_q >= 16'h02bc)
    else $error("reply began before eight bit times");
  AST_NO_CLASH: assert property (!host_true_oe_n |-> dev_true_oe_n)
    else $error("device drives while host sends");
  AST_OE_PAIR: assert property (dev_true_oe_n == dev_comp_oe_n)
    else $error("device enables differ");
  AST_DEV_COMP: assert property (!dev_true_oe_n |-> dev_comp != dev_true)
    else $error("device complement not inverted");
  AST_HOST_COMP: assert property (!host_true_oe_n |-> host_comp != host_true)
    else $error("host complement not inverted");
endmodule

// File: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [6:0] req_addr_i = 7'h00;
  logic [31:0] req_data_i = 32'h0000_0000;
  logic [3:0] reply_delay_setting_i = 4'h0;
  logic [31:0] rd_data_i = 32'h0000_0000;
  logic req_ready_o, rsp_valid_o, rsp_ok_o, wr_stb_o, stb2, err2, err1;
  logic [31:0] rsp_data_o, wr_data_o;
  logic [6:0] reg_addr_o, addr2;
  logic [7:0] datagram_count_o, cnt2, n_wr = 8'h00;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 82;
  int n_err2 = 0;
  int n_stb2 = 0;
  time t_rel = 0;
  logic [31:0] q_rd[$];
  logic [46:0] q_wr[$];
  int q_dl[$];

  swu_link_if lk();
  swu_link_if lk2();
  swu_host swu_host_i(.sys_clk_i, .rst_i, .link(lk), .req_valid_i, .req_write_i,
    .req_addr_i, .req_data_i, .req_ready_o, .rsp_valid_o, .rsp_ok_o, .rsp_data_o);
  swu_device swu_device_i(.sys_clk_i, .rst_i, .link(lk), .reply_delay_setting_i,
    .rd_data_i, .reg_addr_o, .wr_stb_o, .wr_data_o, .datagram_count_o, .rx_err_o(err1));
  // second device faces the bench, which plays a faulty host
  swu_device swu_device_f_i(.sys_clk_i, .rst_i, .link(lk2), .reply_delay_setting_i(4'h0),
    .rd_data_i(32'h0000_0000), .reg_addr_o(addr2), .wr_stb_o(stb2), .wr_data_o(),
    .datagram_count_o(cnt2), .rx_err_o(err2));
  swu_sva swu_sva_i(.sys_clk_i, .rst_i, .host_true(lk.host_true), .host_comp(lk.host_comp),
    .host_true_oe_n(lk.host_true_oe_n), .dev_true(lk.dev_true), .dev_comp(lk.dev_comp),
    .dev_true_oe_n(lk.dev_true_oe_n), .dev_comp_oe_n(lk.dev_comp_oe_n),
    .line_true(lk.line_true));

  always #5 sys_clk_i = ~sys_clk_i;

  // ==========================================
  // reporting
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, runs take about 65k cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================
  // drivers
  task automatic req(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_data_i = d;
    do @(posedge sys_clk_i); while (req_ready_o !== 1'b1);
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    // ready comes back only after any read reply and the guard, so this also paces the link
    do @(posedge sys_clk_i); while (req_ready_o !== 1'b1);
  endtask

  function automatic logic [7:0] crc_of(input logic [47:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 5; k >= 0; k--)
      for (int i = 0; i < 8; i++)
        c = {c[6:0], c[7] ^ c[1] ^ c[0] ^ m[8*k+i]};
    return c;
  endfunction

  // seven framed bytes on the spare link, 100 clocks a bit
  task automatic tx2(input logic [55:0] m);
    lk2.host_true_oe_n = 1'b0;
    lk2.host_comp_oe_n = 1'b0;
    for (int k = 6; k >= 0; k--)
      for (int i = 0; i < 10; i++) begin
        lk2.host_true = (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : m[8*k+i-1]);
        lk2.host_comp = ~lk2.host_true;
        repeat (100) @(negedge sys_clk_i);
      end
    lk2.host_true_oe_n = 1'b1;
    lk2.host_comp_oe_n = 1'b1;
    repeat (2000) @(negedge sys_clk_i);
  endtask

  // ==========================================
  // monitors
  always @(negedge sys_clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      check({rsp_ok_o, rsp_data_o}, {1'b1, q_rd.pop_front()});
      check(datagram_count_o, n_wr);
    end
    if (wr_stb_o === 1'b1)
      check({reg_addr_o, wr_data_o, datagram_count_o}, q_wr.pop_front());
    if (err1 === 1'b1)
      check(err1, 1'b0);
    n_err2 += int'(err2 === 1'b1);
    n_stb2 += int'(stb2 === 1'b1);
  end

  always @(posedge lk.host_true_oe_n) t_rel = $time;

  // reply turn-around time and first reply byte as seen on the wire
  always @(negedge lk.dev_true_oe_n) begin
    logic [8:0] b;
    int g;
    g = int'(($time - t_rel) / 10);
    check(g >= q_dl[0] - 70 && g <= q_dl[0] + 70, 1'b1);
    void'(q_dl.pop_front());
    // the start bit begins with the enable, so sample from here
    #1500;
    check(lk.line_comp, !lk.line_true);
    for (int i = 0; i < 9; i++) begin
      b[i] = lk.line_true;
      #1000;
    end
    check(b, 9'h1f5);
  end

  // ==========================================
  // main sequence
  initial begin
    logic [6:0] a;
    logic [31:0] d;
    logic [55:0] m;
    lk2.host_true = 1'b1;
    lk2.host_comp = 1'b0;
    lk2.host_true_oe_n = 1'b1;
    lk2.host_comp_oe_n = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    fork
      for (int i = 0; i < 3; i++) begin
        a = 7'($random(seed));
        d = $random(seed);
        reply_delay_setting_i = 4'(i * i);
        rd_data_i = d;
        q_rd.push_back(d);
        q_dl.push_back((i == 0 ? 1 : i * i) * 800 - 50);
        req(1'b0, a, 32'h0000_0000);
        check(reg_addr_o, a);
        d = $random(seed);
        n_wr++;
        q_wr.push_back({a, d, n_wr});
        req(1'b1, a, d);
      end
      begin
        repeat (1500) @(negedge sys_clk_i);
        m[55:8] = {8'h05, 1'b1, 7'h2a, 32'(seed)};
        m[7:0] = crc_of(m[55:8]) ^ 8'h01;
        tx2(m);
        check({n_err2[7:0], n_stb2[7:0], cnt2}, 24'h01_0000);
        m[7:0] = crc_of(m[55:8]);
        tx2(m);
        check({n_stb2[7:0], cnt2, addr2}, {8'h01, 8'h01, 7'h2a});
      end
    join
    check(q_rd.size() + q_wr.size() + q_dl.size(), 0);
    print_verdict();
  end
endmodule
